// ### pkg/loop_pkg.sv
package loop_pkg;
   localparam int         ADDR_W              = 9;
   localparam logic [8:0] LOOPBACK_SELECT_OFS = 9'h014;
   localparam logic [7:0] LOOPBACK_SELECT_RST = 8'h00;
   localparam logic [7:0] LOOPBACK_SELECT_MSK = 8'h0f;
   localparam int         ANALOG_BIT          = 0;
   localparam int         FRAMER_BIT          = 1;
   localparam int         LINE_BIT            = 2;
   localparam int         PAYLOAD_BIT         = 3;
   localparam logic [4:0] LAST_SLOT_T1        = 5'h17;
   localparam logic [4:0] LAST_SLOT_E1        = 5'h1f;
   localparam logic [4:0] OVERHEAD_SLOT       = 5'h00;
   localparam int         PIN_SYNC_W          = 7;
endpackage

// ### pkg/frame_mem_if.sv
`timescale 1ns/1ps
interface frame_mem_if #(parameter int AW = 6, parameter int DW = 8);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic          rd_en;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
                 output rd_en, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface

// ### rtl/frame_mem.sv
`timescale 1ns/1ps
module frame_mem
   import loop_pkg::*;
#(
   parameter int AW = 6,
   parameter int DW = 8
) (
   input  wire logic clk,
   frame_mem_if.mem  port
);
   logic [DW-1:0] store [0:(1<<AW)-1];
   logic [DW-1:0] rd_data_r;

   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         store[port.wr_addr] <= port.wr_data;
      end
      if (port.rd_en) begin
         rd_data_r <= store[port.rd_addr];
      end
   end
   assign port.rd_data = rd_data_r;
endmodule

// ### rtl/loopback_path_control.sv
`timescale 1ns/1ps
module loopback_path_control
   import loop_pkg::*;
#(
   parameter int DW = 8
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              up_cs,
   input  wire logic              up_wr,
   input  wire logic              up_rd,
   input  wire logic [ADDR_W-1:0] up_addr,
   input  wire logic [7:0]        up_wdata,
   output      logic [7:0]        up_rdata,
   input  wire logic              line_rx_pos,
   input  wire logic              line_rx_neg,
   input  wire logic              rx_clock_recovery,
   input  wire logic              jat_rx_pos,
   input  wire logic              jat_rx_neg,
   input  wire logic              jitter_attenuator_clock,
   input  wire logic              tx_clock_in,
   input  wire logic              rx_jitter_attenuator,
   input  wire logic              enc_pos,
   input  wire logic              enc_neg,
   input  wire logic              e1_mode,
   input  wire logic              rx_slot_valid,
   input  wire logic [4:0]        rx_slot_num,
   input  wire logic [DW-1:0]     rx_slot_byte,
   input  wire logic              tx_slot_req,
   input  wire logic [4:0]        tx_slot_num,
   input  wire logic              tx_frame_start,
   input  wire logic [DW-1:0]     tx_sys_byte,
   input  wire logic [DW-1:0]     tx_fmt_byte,
   input  wire logic              tx_overhead_source_cfg,
   input  wire logic [31:0]       tx_per_channel_ctrl,
   input  wire logic              framer_slip_event,
   output      logic              line_tx_pos,
   output      logic              line_tx_neg,
   output      logic              tx_line_clock,
   output      logic              dec_pos,
   output      logic              dec_neg,
   output      logic              rx_clock_out,
   output      logic [DW-1:0]     tx_slot_byte,
   output      logic              tx_slot_byte_valid,
   output      logic              slip_error_report,
   output      logic              payload_slip
);
   // Pins from other domains: two flops before use
   logic [PIN_SYNC_W-1:0] meta_r;
   logic [PIN_SYNC_W-1:0] pin_r;
   always_ff @(posedge clk) begin
      meta_r <= {tx_clock_in, jitter_attenuator_clock, jat_rx_neg, jat_rx_pos,
                 rx_clock_recovery, line_rx_neg, line_rx_pos};
      pin_r  <= meta_r;
   end
   logic rxp_s, rxn_s, rclk_s, jp_s, jn_s, jitter_attenuator_clock_s, tclk_s;
   assign {tclk_s, jitter_attenuator_clock_s, jn_s, jp_s, rclk_s, rxn_s, rxp_s} = pin_r;

   // Loopback select register
   logic [7:0] loopback_select_r, loopback_select_nxt;
   logic [7:0] up_rdata_r, up_rdata_nxt;
   logic       hit;
   assign hit = up_cs && (up_addr == LOOPBACK_SELECT_OFS);
   always_comb begin
      loopback_select_nxt = loopback_select_r;
      up_rdata_nxt        = up_rdata_r;
      if (hit && up_wr) begin
         loopback_select_nxt = up_wdata & LOOPBACK_SELECT_MSK;
      end
      if (up_cs && up_rd) begin
         if (hit) begin
            up_rdata_nxt = loopback_select_r;
         end else begin
            up_rdata_nxt = 8'h00;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         loopback_select_r <= LOOPBACK_SELECT_RST;
         up_rdata_r        <= 8'h00;
      end else begin
         loopback_select_r <= loopback_select_nxt;
         up_rdata_r        <= up_rdata_nxt;
      end
   end
   assign up_rdata = up_rdata_r;

   logic payload_return_enable, line_return_enable;
   logic framer_return_enable, analog_return_enable;
   assign payload_return_enable = loopback_select_r[PAYLOAD_BIT];
   assign line_return_enable    = loopback_select_r[LINE_BIT];
   assign framer_return_enable  = loopback_select_r[FRAMER_BIT];
   assign analog_return_enable  = loopback_select_r[ANALOG_BIT];

   // Line side routing; independent muxes so line and framer coexist
   logic lp_r, ln_r, lclk_r, dp_r, dn_r, rco_r;
   logic lp_nxt, ln_nxt, lclk_nxt, dp_nxt, dn_nxt, rco_nxt;
   logic rx_rail_p, rx_rail_n, rx_rail_clk, rx_in_p, rx_in_n;
   always_comb begin
      rx_rail_p   = rx_jitter_attenuator ? jp_s : rxp_s;
      rx_rail_n   = rx_jitter_attenuator ? jn_s : rxn_s;
      rx_rail_clk = rx_jitter_attenuator ? jitter_attenuator_clock_s : rclk_s;
      // Rails are copied as-is, violations included
      lp_nxt   = line_return_enable ? rx_rail_p : enc_pos;
      ln_nxt   = line_return_enable ? rx_rail_n : enc_neg;
      lclk_nxt = line_return_enable ? rx_rail_clk : tclk_s;
      rx_in_p  = analog_return_enable ? lp_r : rx_rail_p;
      rx_in_n  = analog_return_enable ? ln_r : rx_rail_n;
      dp_nxt   = framer_return_enable ? enc_pos : rx_in_p;
      dn_nxt   = framer_return_enable ? enc_neg : rx_in_n;
      rco_nxt  = framer_return_enable ? tclk_s : rx_rail_clk;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lp_r <= 1'b0; ln_r <= 1'b0; lclk_r <= 1'b0;
         dp_r <= 1'b0; dn_r <= 1'b0; rco_r  <= 1'b0;
      end else begin
         lp_r <= lp_nxt; ln_r <= ln_nxt; lclk_r <= lclk_nxt;
         dp_r <= dp_nxt; dn_r <= dn_nxt; rco_r  <= rco_nxt;
      end
   end
   assign line_tx_pos   = lp_r;
   assign line_tx_neg   = ln_r;
   assign tx_line_clock = lclk_r;
   assign dec_pos       = dp_r;
   assign dec_neg       = dn_r;
   assign rx_clock_out  = rco_r;

   // Two-frame payload buffer, bank = frame, address low bits = slot
   frame_mem_if #(.AW(6), .DW(DW)) mport ();
   frame_mem #(.AW(6), .DW(DW)) u_mem (
      .clk  (clk),
      .port (mport.mem)
   );

   logic       rx_bank_r, rx_bank_nxt, tx_bank_r, tx_bank_nxt;
   logic       rx_new_r, rx_new_nxt;
   logic       slip_r, slip_nxt, serr_r, serr_nxt;
   logic       rx_frame_end, tx_rd_bank;
   logic [4:0] last_slot;
   assign last_slot    = e1_mode ? LAST_SLOT_E1 : LAST_SLOT_T1;
   assign rx_frame_end = rx_slot_valid && (rx_slot_num == last_slot);
   // Frame start reads the newest full bank without waiting
   assign tx_rd_bank   = tx_frame_start ? ~rx_bank_r : tx_bank_r;

   assign mport.wr_en   = rx_slot_valid;
   assign mport.wr_addr = {rx_bank_r, rx_slot_num};
   assign mport.wr_data = rx_slot_byte;
   assign mport.rd_en   = tx_slot_req;
   assign mport.rd_addr = {tx_rd_bank, tx_slot_num};

   always_comb begin
      rx_bank_nxt = rx_frame_end ? ~rx_bank_r : rx_bank_r;
      rx_new_nxt  = rx_new_r;
      tx_bank_nxt = tx_bank_r;
      slip_nxt    = 1'b0;
      if (tx_frame_start) begin
         tx_bank_nxt = ~rx_bank_r;
         // No fresh frame since last start: frame is repeated
         slip_nxt    = payload_return_enable && !rx_new_r;
         rx_new_nxt  = 1'b0;
      end
      if (rx_frame_end) begin
         rx_new_nxt = 1'b1;
      end
      serr_nxt = framer_slip_event;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_bank_r <= 1'b0;
         tx_bank_r <= 1'b1;
         rx_new_r  <= 1'b0;
         slip_r    <= 1'b0;
         serr_r    <= 1'b0;
      end else begin
         rx_bank_r <= rx_bank_nxt;
         tx_bank_r <= tx_bank_nxt;
         rx_new_r  <= rx_new_nxt;
         slip_r    <= slip_nxt;
         serr_r    <= serr_nxt;
      end
   end
   assign payload_slip      = slip_r;
   assign slip_error_report = serr_r;

   // Transmit byte select, one stage after memory read
   logic          req_d_r, req_d_nxt, ovh_d_r, ovh_d_nxt, pcc_d_r, pcc_d_nxt;
   logic [DW-1:0] sys_d_r, sys_d_nxt, fmt_d_r, fmt_d_nxt;
   logic [DW-1:0] txb_r, txb_nxt;
   logic          txv_r, txv_nxt;
   always_comb begin
      req_d_nxt = tx_slot_req;
      ovh_d_nxt = tx_slot_req && !e1_mode ? 1'b0 : (tx_slot_num == OVERHEAD_SLOT);
      pcc_d_nxt = tx_per_channel_ctrl[tx_slot_num];
      sys_d_nxt = tx_sys_byte;
      fmt_d_nxt = tx_fmt_byte;
      txv_nxt   = req_d_r;
      txb_nxt   = txb_r;
      if (req_d_r) begin
         if (ovh_d_r) begin
            txb_nxt = tx_overhead_source_cfg ? sys_d_r : fmt_d_r;
         end else if (pcc_d_r) begin
            txb_nxt = sys_d_r;
         end else if (payload_return_enable) begin
            txb_nxt = mport.rd_data;
         end else begin
            txb_nxt = sys_d_r;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         req_d_r <= 1'b0; ovh_d_r <= 1'b0; pcc_d_r <= 1'b0;
         sys_d_r <= '0;   fmt_d_r <= '0;
         txb_r   <= '0;   txv_r   <= 1'b0;
      end else begin
         req_d_r <= req_d_nxt; ovh_d_r <= ovh_d_nxt; pcc_d_r <= pcc_d_nxt;
         sys_d_r <= sys_d_nxt; fmt_d_r <= fmt_d_nxt;
         txb_r   <= txb_nxt;   txv_r   <= txv_nxt;
      end
   end
   assign tx_slot_byte       = txb_r;
   assign tx_slot_byte_valid = txv_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_reserved_zero: assert property ((loopback_select_r & ~LOOPBACK_SELECT_MSK) == 8'h00)
      else $error("reserved loopback bits set");
   chk_write_takes: assert property (hit && up_wr |=> loopback_select_r == ($past(up_wdata) & 8'h0f))
      else $error("loopback write not stored");
   chk_line_data: assert property (line_return_enable |=> line_tx_pos == $past(rx_rail_p))
      else $error("line loopback data wrong");
   chk_line_normal: assert property (!line_return_enable |=> line_tx_neg == $past(enc_neg))
      else $error("encoder not driving line");
   chk_framer_dec: assert property (framer_return_enable |=> dec_pos == $past(enc_pos))
      else $error("framer loopback data wrong");
   chk_framer_clk: assert property (framer_return_enable |=> rx_clock_out == $past(tclk_s))
      else $error("framer loopback clock wrong");
   chk_analog_dec: assert property (analog_return_enable && !framer_return_enable
                                    |=> dec_neg == $past(ln_r))
      else $error("analog loopback data wrong");
   chk_pcc_wins: assert property (tx_slot_req && tx_per_channel_ctrl[tx_slot_num]
                                  && !(tx_slot_num == OVERHEAD_SLOT && e1_mode)
                                  |=> ##1 tx_slot_byte == $past(tx_sys_byte, 2))
      else $error("per-channel selection overridden");
   chk_slip_quiet: assert property (payload_slip |-> !slip_error_report || $past(framer_slip_event))
      else $error("payload slip reported as error");
   chk_byte_valid: assert property (tx_slot_req |=> ##1 tx_slot_byte_valid)
      else $error("transmit byte late");

   cov_payload: cover property (payload_return_enable && tx_slot_byte_valid);
   cov_line_framer: cover property (line_return_enable && framer_return_enable);
   cov_slip: cover property (payload_slip);
   cov_analog: cover property (analog_return_enable && !framer_return_enable);
endmodule

// ### verif/line_far_end.sv
`timescale 1ns/1ps
module line_far_end #(
   parameter logic [31:0] SEED = 32'h2a6b1d3c
) (
   input  wire logic clk,
   output      logic line_rx_pos,
   output      logic line_rx_neg,
   output      logic rx_clock_recovery,
   output      logic jat_rx_pos,
   output      logic jat_rx_neg,
   output      logic jitter_attenuator_clock,
   output      logic tx_clock_in
);
   integer     seed_v = SEED;
   logic [6:0] rnd;
   initial begin
      {line_rx_pos, line_rx_neg, rx_clock_recovery} = 3'h0;
      {jat_rx_pos, jat_rx_neg, jitter_attenuator_clock, tx_clock_in} = 4'h0;
   end
   // Both rails high is legal, so violations travel the loop
   always @(negedge clk) begin
      rnd = 7'($random(seed_v));
      {line_rx_neg, line_rx_pos} <= rnd[1:0];
      rx_clock_recovery <= rnd[2];
      {jat_rx_neg, jat_rx_pos} <= rnd[4:3];
      jitter_attenuator_clock <= rnd[5];
      tx_clock_in <= rnd[6];
   end
endmodule

// ### verif/t1e1_loopback_path_control_tb_top.sv
`timescale 1ns/1ps
module t1e1_loopback_path_control_tb_top;
   import loop_pkg::*;
   logic              clk, reset_n, up_cs, up_wr, up_rd, e1_mode;
   logic [ADDR_W-1:0] up_addr;
   logic [7:0]        up_wdata, up_rdata, rx_slot_byte, tx_sys_byte, tx_fmt_byte;
   logic [7:0]        tx_slot_byte, mode, e;
   logic              line_rx_pos, line_rx_neg, rx_clock_recovery, jat_rx_pos, jat_rx_neg;
   logic              jitter_attenuator_clock, tx_clock_in, rx_jitter_attenuator;
   logic              enc_pos, enc_neg, rx_slot_valid, tx_slot_req, tx_frame_start;
   logic [4:0]        rx_slot_num, tx_slot_num;
   logic              tx_overhead_source_cfg, framer_slip_event, line_tx_pos, line_tx_neg;
   logic [31:0]       tx_per_channel_ctrl, rnd;
   logic              tx_line_clock, dec_pos, dec_neg, rx_clock_out, tx_slot_byte_valid;
   logic              slip_error_report, payload_slip;
   logic [8:0]        h0, h1, h2;
   logic [2:0]        r;
   logic [7:0]        rxb [32];
   logic [7:0]        mtab [7] = '{8'h00, 8'h04, 8'h14, 8'h02, 8'h06, 8'h01, 8'h0c};
   integer            seed = 32'h5fb63ec9;
   int                err_count = 0, n_compared = 0, settle = 30, slip_seen, slip_err = 0;

   loopback_path_control dut (
      .clk                     (clk),
      .reset_n                 (reset_n),
      .up_cs                   (up_cs),
      .up_wr                   (up_wr),
      .up_rd                   (up_rd),
      .up_addr                 (up_addr),
      .up_wdata                (up_wdata),
      .up_rdata                (up_rdata),
      .line_rx_pos             (line_rx_pos),
      .line_rx_neg             (line_rx_neg),
      .rx_clock_recovery       (rx_clock_recovery),
      .jat_rx_pos              (jat_rx_pos),
      .jat_rx_neg              (jat_rx_neg),
      .jitter_attenuator_clock (jitter_attenuator_clock),
      .tx_clock_in             (tx_clock_in),
      .rx_jitter_attenuator    (rx_jitter_attenuator),
      .enc_pos                 (enc_pos),
      .enc_neg                 (enc_neg),
      .e1_mode                 (e1_mode),
      .rx_slot_valid           (rx_slot_valid),
      .rx_slot_num             (rx_slot_num),
      .rx_slot_byte            (rx_slot_byte),
      .tx_slot_req             (tx_slot_req),
      .tx_slot_num             (tx_slot_num),
      .tx_frame_start          (tx_frame_start),
      .tx_sys_byte             (tx_sys_byte),
      .tx_fmt_byte             (tx_fmt_byte),
      .tx_overhead_source_cfg  (tx_overhead_source_cfg),
      .tx_per_channel_ctrl     (tx_per_channel_ctrl),
      .framer_slip_event       (framer_slip_event),
      .line_tx_pos             (line_tx_pos),
      .line_tx_neg             (line_tx_neg),
      .tx_line_clock           (tx_line_clock),
      .dec_pos                 (dec_pos),
      .dec_neg                 (dec_neg),
      .rx_clock_out            (rx_clock_out),
      .tx_slot_byte            (tx_slot_byte),
      .tx_slot_byte_valid      (tx_slot_byte_valid),
      .slip_error_report       (slip_error_report),
      .payload_slip            (payload_slip)
   );
   line_far_end far (
      .clk                     (clk),
      .line_rx_pos             (line_rx_pos),
      .line_rx_neg             (line_rx_neg),
      .rx_clock_recovery       (rx_clock_recovery),
      .jat_rx_pos              (jat_rx_pos),
      .jat_rx_neg              (jat_rx_neg),
      .jitter_attenuator_clock (jitter_attenuator_clock),
      .tx_clock_in             (tx_clock_in)
   );

   always #4 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(negedge clk) {enc_neg, enc_pos} <= 2'($random(seed));

   // Reference model of the line paths, pins 3 cycles, encoder 1
   always @(negedge clk) begin
      h2 = h1;
      h1 = h0;
      h0 = {enc_neg, enc_pos, tx_clock_in, jitter_attenuator_clock, jat_rx_neg, jat_rx_pos,
            rx_clock_recovery, line_rx_neg, line_rx_pos};
      r = rx_jitter_attenuator ? h2[5:3] : h2[2:0];
      if (payload_slip)
         slip_seen++;
      if (slip_error_report)
         slip_err++;
      if (settle > 0)
         settle--;
      else begin
         check({line_tx_neg, line_tx_pos}, mode[2] ? r[1:0] : h0[8:7]);
         check(tx_line_clock, mode[2] ? r[2] : h2[6]);
         check({dec_neg, dec_pos}, mode[1] ? h0[8:7] : mode[0] ? h1[8:7] : r[1:0]);
         if (mode[1:0] != 2'b01)
            check(rx_clock_out, mode[1] ? h2[6] : r[2]);
      end
   end

   task automatic host(input logic wr, input logic [8:0] a, input logic [7:0] d);
      up_cs = 1'b1;
      up_wr = wr;
      up_rd = !wr;
      up_addr = a;
      up_wdata = d;
      @(negedge clk);
      up_cs = 1'b0;
      up_wr = 1'b0;
      up_rd = 1'b0;
      // Idle edge so a following access never re-raises a strobe in one step
      @(negedge clk);
   endtask

   task automatic set_mode(input logic [7:0] wv, input logic sel);
      settle = 8;
      host(1'b1, LOOPBACK_SELECT_OFS, wv);
      mode = wv & LOOPBACK_SELECT_MSK;
      rx_jitter_attenuator = sel;
      host(1'b0, LOOPBACK_SELECT_OFS, 8'h00);
      check(up_rdata, mode);
   endtask

   task automatic rx_frame(input int n);
      for (int s = 0; s < n; s++) begin
         rnd = $random(seed);
         rxb[s] = rnd[7:0];
         rx_slot_valid = 1'b1;
         rx_slot_num = 5'(s);
         rx_slot_byte = rnd[7:0];
         @(negedge clk);
         rx_slot_valid = 1'b0;
         @(negedge clk);
      end
   endtask

   task automatic tx_frame(input int n, input int exp_slip);
      slip_seen = 0;
      for (int s = 0; s < n; s++) begin
         rnd = $random(seed);
         tx_slot_req = 1'b1;
         tx_slot_num = 5'(s);
         tx_frame_start = (s == 0);
         tx_sys_byte = rnd[7:0];
         tx_fmt_byte = rnd[15:8];
         if (e1_mode && s == 0)
            e = tx_overhead_source_cfg ? rnd[7:0] : rnd[15:8];
         else if (tx_per_channel_ctrl[s] || !mode[3])
            e = rnd[7:0];
         else
            e = rxb[s];
         @(negedge clk);
         tx_slot_req = 1'b0;
         tx_frame_start = 1'b0;
         check(tx_slot_byte_valid, 0);
         @(negedge clk);
         check({tx_slot_byte_valid, tx_slot_byte}, {1'b1, e});
      end
      if (mode[3])
         check(slip_seen, exp_slip);
      check(slip_err, 0);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      results();
   end

   initial begin
      {clk, reset_n, up_cs, up_wr, up_rd, e1_mode, rx_jitter_attenuator} = 7'h00;
      {up_addr, up_wdata, mode, rx_slot_valid, tx_slot_req, tx_frame_start} = 28'h0;
      {rx_slot_num, tx_slot_num, rx_slot_byte, tx_sys_byte, tx_fmt_byte} = 34'h0;
      {tx_overhead_source_cfg, framer_slip_event, tx_per_channel_ctrl} = 34'h0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      host(1'b0, LOOPBACK_SELECT_OFS, 8'h00);
      check(up_rdata, LOOPBACK_SELECT_RST);
      host(1'b1, 9'h015, 8'hff);
      host(1'b0, 9'h015, 8'h00);
      check(up_rdata, 8'h00);
      for (int i = 0; i < 7; i++) begin
         rnd = $random(seed);
         set_mode({rnd[7:4], mtab[i][3:0]}, mtab[i][4]);
         repeat (40) @(negedge clk);
      end
      for (int m = 0; m < 2; m++) begin
         e1_mode = (m == 0);
         rnd = $random(seed);
         tx_per_channel_ctrl = rnd & 32'h0f0f_f0f0;
         tx_overhead_source_cfg = rnd[2];
         set_mode(8'h08, 1'b0);
         rx_frame(e1_mode ? 32 : 24);
         tx_frame(e1_mode ? 32 : 24, 0);
         tx_frame(e1_mode ? 32 : 24, 1);
         // Other overhead source on the next frame
         tx_overhead_source_cfg = !tx_overhead_source_cfg;
         set_mode(8'h00, 1'b0);
         tx_frame(e1_mode ? 32 : 24, 0);
      end
      // Framer slip errors still reach the report, payload slips never did
      framer_slip_event = 1'b1;
      @(negedge clk);
      framer_slip_event = 1'b0;
      repeat (2) @(negedge clk);
      check(slip_err, 1);
      results();
   end
endmodule
